// ===== verilog/rbd_pkg.sv
/*
 * rbd_pkg: constants, field layouts and enumerations for the reset, boot-strap
 * and address-decode block.
 * assumes: included nowhere; every user names items as rbd_pkg::name.
 */
package rbd_pkg;

   // clocking and strap timing
   localparam int CORE_CLK_HZ = 250_000_000;
   localparam int SLOW_CLK_HZ = 32768; // master clock source at reset
   localparam int STRAP_CYC = 10; // cycles a strap must hold before release
   localparam int WDOG_RST_CYC = 4; // cycles a watchdog-made reset is held after its request

   // address map
   localparam logic [9:0] TOP_INT = 10'h000; // lowest four megabytes
   localparam logic [9:0] TOP_PER = 10'h3ff; // highest four megabytes
   localparam logic [31:0] EXT_BASE = 32'h0040_0000;
   localparam logic [31:0] EXT_END = 32'hffc0_0000;
   localparam int BANK_SHIFT = 24; // 16-Mbyte banks
   localparam int NUM_BANKS = 8;
   localparam logic [21:0] SRAM_ALT_BASE = 22'h10_0000; // sram alias before remap
   localparam logic [9:0] IRQC_PAGE = 10'h3ff; // 4-Kbyte page of the irq controller

   // access sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;

   // register offsets
   localparam logic [7:0] OFS_REMAP = 8'h00;
   localparam logic [7:0] OFS_STRAP = 8'h04;
   localparam logic [7:0] OFS_FEAT_EN = 8'h08;
   localparam logic [7:0] OFS_FEAT_DIS = 8'h0c;
   localparam logic [7:0] OFS_FEAT_ST = 8'h10;
   localparam logic [7:0] OFS_BANK_BASE = 8'h20;

   // field positions and widths
   localparam int REMAP_BIT = 0;
   localparam int ST_BOOT = 0;
   localparam int ST_TRI = 1;
   localparam int ST_DBG = 2;
   localparam int ST_CAUSE = 4;
   localparam int FEAT_PLL = 0;
   localparam int FEAT_MCKO = 1;
   localparam int FEAT_W = 2;
   localparam int BCFG_W8 = 0;
   localparam int BCFG_W = 6; // width8, wait[3:1], float[5:4]

   // reset values
   localparam logic [FEAT_W-1:0] FEAT_RST = 2'h0;
   localparam logic [BCFG_W-1:0] BCFG_RST = 6'h00;

   // boundary-scan instruction codes
   localparam logic [3:0] SCAN_EXTEST = 4'h0;
   localparam logic [3:0] SCAN_SAMPLE = 4'h1;
   localparam logic [3:0] SCAN_BYPASS = 4'hf;

   typedef enum logic [1:0] {
      TGT_NONE = 2'b00,
      TGT_SRAM = 2'b01,
      TGT_BANK = 2'b11,
      TGT_PER = 2'b10
   } rbd_tgt_e;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_EXT = 2'b01,
      CAUSE_WDOG = 2'b11
   } rbd_cause_e;

   typedef enum logic [1:0] {
      SOP_BYPASS = 2'b00,
      SOP_SAMPLE = 2'b01,
      SOP_EXTEST = 2'b11
   } rbd_scan_e;

endpackage

// ===== verilog/rbd_top.sv
/*
 * rbd_top: reset handling, reset-time strap capture, debug port selection,
 * remap, address decode with abort, and the internal 32-bit sram.
 * assumes: all pins arrive asynchronous to core_clk; the watchdog request,
 * scan instruction, cpu access port and register port are on core_clk.
 */
// The plain strobed port and the address map were chosen for this implementation.
//
// Contract
// - any reset restores registers and clears remap so fetch starts at zero
// - external reset asserts at once; its release is synchronised to the clock
// - test-port reset reaches only the controller chosen at last external reset
// - watchdog reset acts like external reset but keeps the straps
// - external reset wins over a simultaneous watchdog reset
// - tri-state strap low ten cycles before release disables all pad drivers
// - debug select low enables in-circuit debug, high enables boundary scan
// - boundary scan offers only sample, extest and bypass, no id code
// - decode splits space into internal, external and peripheral regions
// - 8-Kbyte 32-bit sram does byte, half and word access in one cycle
// - boot strap picks 8-bit (1) or 16-bit (0) boot memory on bank zero
// - remap write puts sram at zero; only a reset undoes it
// - external banks one to seven are reachable only after remap
// - abort only for undefined external addresses, never internal ones
// - external space holds eight 16-Mbyte banks, each with its own timing
// - peripheral accesses are forced to aligned whole words
// - peripherals decode 16-Kbyte windows, the irq controller 4 Kbytes; here only the irq controller page is flagged
// - enable writes set, disable writes clear, zeros ignored, reserved reads zero
// - master clock source is chosen by software between slow and pll clock
`timescale 1ns/1ns
module rbd_top #(
   parameter int SRAM_WORDS = 2048,
   parameter int STRAP_CYC = rbd_pkg::STRAP_CYC,
   parameter int WDOG_RST_CYC = rbd_pkg::WDOG_RST_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ext_reset_n,
   input wire logic test_port_reset_n,
   input wire logic debug_port_select,
   input wire logic boot_width_strap,
   input wire logic tristate_strap_n,
   input wire logic wdog_reset_req,
   input wire logic [3:0] scan_ir,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic [1:0] cpu_size,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   output logic sys_reset_n_q,
   output logic ice_reset_n_q,
   output logic scan_reset_n_q,
   output logic ice_enable_q,
   output logic scan_enable_q,
   output logic [1:0] scan_op_q,
   output logic pad_drive_en_q,
   output logic mclk_src_pll_q,
   output logic mclk_out_en_q,
   output logic remap_q,
   output logic dec_valid_q,
   output logic [1:0] dec_tgt_q,
   output logic dec_abort_q,
   output logic [2:0] dec_bank_q,
   output logic [5:0] dec_bank_cfg_q,
   output logic [31:0] dec_addr_q,
   output logic per_irqc_q,
   output logic bank0_select_n_q,
   output logic [31:0] sram_rdata_q
);

   localparam int SRAM_AW = $clog2(SRAM_WORDS);

   // refuse sizes the decode cannot serve
   if (SRAM_WORDS < 2 || SRAM_WORDS > 1024 * 1024 || (SRAM_WORDS & (SRAM_WORDS - 1)) != 0)
      $error("SRAM_WORDS must be a power of two within the internal region");
   if (STRAP_CYC < 1 || STRAP_CYC > 255)
      $error("STRAP_CYC out of range");
   if (WDOG_RST_CYC < 1 || WDOG_RST_CYC > 255)
      $error("WDOG_RST_CYC out of range");

   // byte lanes touched by a little-endian access
   function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] a);
      logic [3:0] m;
      m = 4'hf;
      if (size == rbd_pkg::SZ_BYTE) begin
         m = 4'h1 << a;
      end else if (size == rbd_pkg::SZ_HALF) begin
         m = a[1] ? 4'hc : 4'h3;
      end
      return m;
   endfunction

   // pin synchronisers: {test reset, debug select, boot strap, tri strap}
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= 4'hf;
         pin_s2_q <= 4'hf;
      end else begin
         pin_s1_q <= {test_port_reset_n, debug_port_select, boot_width_strap, tristate_strap_n};
         pin_s2_q <= pin_s1_q;
      end
   end

   // external reset: asynchronous assert, synchronised release
   logic ext_arst_n;
   logic rsync1_q;
   logic rsync2_q;
   assign ext_arst_n = rst_b & ext_reset_n;
   always_ff @(posedge core_clk or negedge ext_arst_n) begin
      if (!ext_arst_n) begin
         rsync1_q <= 1'b0;
         rsync2_q <= 1'b0;
      end else begin
         rsync1_q <= 1'b1;
         rsync2_q <= rsync1_q;
      end
   end

   // release edge of the synchronised external reset
   logic ext_prev_q;
   logic ext_release;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= rsync2_q;
      end
   end
   assign ext_release = rsync2_q & ~ext_prev_q;

   // watchdog reset stretch; external reset takes it over
   logic [7:0] wd_cnt_q;
   logic int_reset;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wd_cnt_q <= 8'h00;
      end else if (!rsync2_q) begin
         wd_cnt_q <= 8'h00;
      end else if (wdog_reset_req) begin
         wd_cnt_q <= 8'(WDOG_RST_CYC);
      end else if (wd_cnt_q != 8'h00) begin
         wd_cnt_q <= wd_cnt_q - 8'h01;
      end
   end
   assign int_reset = ~rsync2_q | wdog_reset_req | (wd_cnt_q != 8'h00);

   // system reset out, asserted at once by the pin
   always_ff @(posedge core_clk or negedge ext_arst_n) begin
      if (!ext_arst_n) begin
         sys_reset_n_q <= 1'b0;
      end else begin
         sys_reset_n_q <= ~int_reset;
      end
   end

   // tri-state hold counter runs while the external reset is held and the tri strap is low; boot level tracked
   logic [7:0] tri_cnt_q;
   logic boot_last_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tri_cnt_q <= 8'h00;
         boot_last_q <= 1'b1;
      end else begin
         boot_last_q <= pin_s2_q[1];
         if (rsync2_q || pin_s2_q[0]) begin
            tri_cnt_q <= 8'h00;
         end else if (tri_cnt_q != 8'hff) begin
            tri_cnt_q <= tri_cnt_q + 8'h01;
         end
      end
   end

   // straps latched only at external release, kept through watchdog resets
   logic boot_width_q;
   logic tri_mode_q;
   logic debug_sel_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_width_q <= 1'b0;
         tri_mode_q <= 1'b0;
         debug_sel_q <= 1'b0;
      end else if (ext_release) begin
         // boot strap taken from its synchronised level one cycle before release
         boot_width_q <= boot_last_q;
         tri_mode_q <= (tri_cnt_q >= 8'(STRAP_CYC));
         debug_sel_q <= pin_s2_q[2];
      end
   end

   // reset cause, readable by software
   rbd_pkg::rbd_cause_e cause_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cause_q <= rbd_pkg::CAUSE_EXT;
      end else if (!rsync2_q) begin
         cause_q <= rbd_pkg::CAUSE_EXT;
      end else if (wdog_reset_req) begin
         cause_q <= rbd_pkg::CAUSE_WDOG;
      end
   end

   // debug port selection, test reset routing and scan instructions
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ice_enable_q <= 1'b0;
         scan_enable_q <= 1'b0;
         ice_reset_n_q <= 1'b0;
         scan_reset_n_q <= 1'b0;
         scan_op_q <= rbd_pkg::SOP_BYPASS;
         pad_drive_en_q <= 1'b0;
      end else begin
         ice_enable_q <= ~debug_sel_q;
         scan_enable_q <= debug_sel_q;
         ice_reset_n_q <= pin_s2_q[3] | debug_sel_q;
         scan_reset_n_q <= pin_s2_q[3] | ~debug_sel_q;
         pad_drive_en_q <= ~tri_mode_q;
         case (scan_ir)
            rbd_pkg::SCAN_EXTEST: scan_op_q <= rbd_pkg::SOP_EXTEST;
            rbd_pkg::SCAN_SAMPLE: scan_op_q <= rbd_pkg::SOP_SAMPLE;
            default: scan_op_q <= rbd_pkg::SOP_BYPASS;
         endcase
      end
   end

   // register port decode
   logic wr_remap;
   logic wr_en;
   logic wr_dis;
   assign wr_remap = reg_wr && reg_addr == rbd_pkg::OFS_REMAP;
   assign wr_en = reg_wr && reg_addr == rbd_pkg::OFS_FEAT_EN;
   assign wr_dis = reg_wr && reg_addr == rbd_pkg::OFS_FEAT_DIS;

   // remap flop: set by command, cleared by any reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         remap_q <= 1'b0;
      end else if (int_reset) begin
         remap_q <= 1'b0;
      end else if (wr_remap && reg_wdata[rbd_pkg::REMAP_BIT]) begin
         remap_q <= 1'b1;
      end
   end

   // enable/disable/status feature bits: clock source and clock output
   logic [rbd_pkg::FEAT_W-1:0] feat_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         feat_q <= rbd_pkg::FEAT_RST;
      end else if (int_reset) begin
         feat_q <= rbd_pkg::FEAT_RST;
      end else begin
         feat_q <= (feat_q | (wr_en ? reg_wdata[rbd_pkg::FEAT_W-1:0] : '0))
                   & ~(wr_dis ? reg_wdata[rbd_pkg::FEAT_W-1:0] : '0);
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mclk_src_pll_q <= 1'b0;
         mclk_out_en_q <= 1'b0;
      end else begin
         mclk_src_pll_q <= feat_q[rbd_pkg::FEAT_PLL];
         mclk_out_en_q <= feat_q[rbd_pkg::FEAT_MCKO];
      end
   end

   // per-bank width, wait states and float time; bank zero width from strap
   logic [rbd_pkg::BCFG_W-1:0] bank_cfg_q [rbd_pkg::NUM_BANKS];
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < rbd_pkg::NUM_BANKS; i++) begin
            bank_cfg_q[i] <= rbd_pkg::BCFG_RST;
         end
      end else if (int_reset) begin
         for (int i = 0; i < rbd_pkg::NUM_BANKS; i++) begin
            bank_cfg_q[i] <= rbd_pkg::BCFG_RST;
         end
         bank_cfg_q[0][rbd_pkg::BCFG_W8] <= boot_width_q;
      end else if (ext_release) begin
         // the fresh boot strap sets the bank zero width at release
         bank_cfg_q[0][rbd_pkg::BCFG_W8] <= boot_last_q;
      end else if (reg_wr) begin
         for (int i = 0; i < rbd_pkg::NUM_BANKS; i++) begin
            if (reg_addr == rbd_pkg::OFS_BANK_BASE + 8'(4 * i)) begin
               bank_cfg_q[i] <= reg_wdata[rbd_pkg::BCFG_W-1:0];
            end
         end
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         rbd_pkg::OFS_REMAP: rd_mux[rbd_pkg::REMAP_BIT] = remap_q;
         rbd_pkg::OFS_STRAP: begin
            rd_mux[rbd_pkg::ST_BOOT] = boot_width_q;
            rd_mux[rbd_pkg::ST_TRI] = tri_mode_q;
            rd_mux[rbd_pkg::ST_DBG] = debug_sel_q;
            rd_mux[rbd_pkg::ST_CAUSE +: 2] = cause_q;
         end
         rbd_pkg::OFS_FEAT_ST: rd_mux[rbd_pkg::FEAT_W-1:0] = feat_q;
         default: begin
            for (int i = 0; i < rbd_pkg::NUM_BANKS; i++) begin
               if (reg_addr == rbd_pkg::OFS_BANK_BASE + 8'(4 * i)) begin
                  rd_mux[rbd_pkg::BCFG_W-1:0] = bank_cfg_q[i];
               end
            end
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // address decode of the cpu access
   rbd_pkg::rbd_tgt_e tgt;
   logic abort;
   logic [2:0] bank;
   logic [31:0] ext_off;
   logic sram_hit;
   always_comb begin
      tgt = rbd_pkg::TGT_NONE;
      abort = 1'b0;
      bank = 3'h0;
      ext_off = cpu_addr - rbd_pkg::EXT_BASE;
      sram_hit = 1'b0;
      if (cpu_addr[31:22] == rbd_pkg::TOP_INT) begin
         if (remap_q || cpu_addr[21:13] == rbd_pkg::SRAM_ALT_BASE[21:13]) begin
            sram_hit = remap_q ? (cpu_addr[21:2] < 20'(SRAM_WORDS)) : 1'b1;
            tgt = sram_hit ? rbd_pkg::TGT_SRAM : rbd_pkg::TGT_NONE;
         end else begin
            tgt = rbd_pkg::TGT_BANK; // boot memory at zero before remap
         end
      end else if (cpu_addr[31:22] == rbd_pkg::TOP_PER) begin
         tgt = rbd_pkg::TGT_PER;
      end else begin
         bank = ext_off[rbd_pkg::BANK_SHIFT +: 3];
         if (ext_off[31:rbd_pkg::BANK_SHIFT + 3] != '0 || (!remap_q && bank != 3'h0)) begin
            abort = 1'b1;
         end else begin
            tgt = rbd_pkg::TGT_BANK;
         end
      end
   end

   // registered decode results
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dec_valid_q <= 1'b0;
         dec_tgt_q <= rbd_pkg::TGT_NONE;
         dec_abort_q <= 1'b0;
         dec_bank_q <= 3'h0;
         dec_bank_cfg_q <= rbd_pkg::BCFG_RST;
         dec_addr_q <= 32'h0000_0000;
         per_irqc_q <= 1'b0;
         bank0_select_n_q <= 1'b1;
      end else begin
         dec_valid_q <= cpu_req && !int_reset;
         dec_tgt_q <= tgt;
         dec_abort_q <= cpu_req && !int_reset && abort;
         dec_bank_q <= bank;
         dec_bank_cfg_q <= bank_cfg_q[bank];
         bank0_select_n_q <= !(cpu_req && !int_reset && tgt == rbd_pkg::TGT_BANK
                              && bank == 3'h0);
         if (tgt == rbd_pkg::TGT_PER) begin
            dec_addr_q <= {cpu_addr[31:2], 2'b00};
            per_irqc_q <= cpu_addr[21:12] == rbd_pkg::IRQC_PAGE;
         end else begin
            dec_addr_q <= cpu_addr;
            per_irqc_q <= 1'b0;
         end
      end
   end

   // internal sram, byte lanes written in one cycle
   logic [31:0] sram_mem [SRAM_WORDS];
   logic [3:0] lanes;
   logic [SRAM_AW-1:0] sram_idx;
   assign lanes = lane_mask(cpu_size, cpu_addr[1:0]);
   assign sram_idx = cpu_addr[SRAM_AW+1:2];
   always_ff @(posedge core_clk) begin
      if (cpu_req && cpu_write && !int_reset && sram_hit) begin
         for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
               sram_mem[sram_idx][8*b +: 8] <= cpu_wdata[8*b +: 8];
            end
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sram_rdata_q <= 32'h0000_0000;
      end else if (cpu_req && !cpu_write && sram_hit) begin
         sram_rdata_q <= sram_mem[sram_idx];
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   remap_clear_a: assert property (int_reset |=> !remap_q)
      else $error("remap survived a reset");
   remap_set_a: assert property (!int_reset && wr_remap && reg_wdata[0] |=> remap_q)
      else $error("remap command not taken");
   tri_entry_a: assert property (ext_release && tri_cnt_q >= 8'(STRAP_CYC)
      |=> ##1 !pad_drive_en_q)
      else $error("tri-state mode not entered");
   wdog_keep_a: assert property (rsync2_q && ext_prev_q |=> $stable(boot_width_q)
      && $stable(tri_mode_q))
      else $error("straps changed without external reset");
   ext_prio_a: assert property (!rsync2_q |=> wd_cnt_q == 8'h00)
      else $error("watchdog reset not overridden");
   wdog_reset_a: assert property (wdog_reset_req && rsync2_q
      |=> !sys_reset_n_q && wd_cnt_q == 8'(WDOG_RST_CYC))
      else $error("watchdog reset not started");
   wdog_hold_a: assert property (wd_cnt_q != 8'h00 |=> !sys_reset_n_q)
      else $error("watchdog reset too short");
   abort_int_a: assert property (dec_valid_q && dec_tgt_q != rbd_pkg::TGT_NONE
      |-> !dec_abort_q)
      else $error("abort on a defined target");
   per_word_a: assert property (dec_valid_q && dec_tgt_q == rbd_pkg::TGT_PER
      |-> dec_addr_q[1:0] == 2'b00)
      else $error("peripheral access not word aligned");
   bank_lock_a: assert property (cpu_req && !int_reset && !remap_q
      && cpu_addr[31:22] != 10'h000 && cpu_addr[31:22] != 10'h3ff
      && ext_off[26:24] != 3'h0 |=> dec_abort_q)
      else $error("bank reachable before remap");
   tap_sel_a: assert property (!pin_s2_q[3] && debug_sel_q
      |=> !scan_reset_n_q && ice_reset_n_q)
      else $error("test reset reached wrong controller");
   feat_set_a: assert property (!int_reset && wr_en && reg_wdata[0]
      |=> ##1 mclk_src_pll_q)
      else $error("enable write did not set status");

   remap_seen_c: cover property (!remap_q ##1 remap_q);
   wdog_seen_c: cover property (wdog_reset_req && rsync2_q);
   tri_seen_c: cover property (ext_release && tri_cnt_q >= 8'(STRAP_CYC));
   abort_seen_c: cover property (dec_abort_q);

endmodule

// ===== test/rbd_cpu_model.sv
/*
 * rbd_cpu_model: processor side of the decode port, one access per call.
 * assumes: callers wait for the system reset release before calling access.
 */
`timescale 1ns/1ns
module rbd_cpu_model (
   input wire logic core_clk,
   output logic cpu_req,
   output logic cpu_write,
   output logic [1:0] cpu_size,
   output logic [31:0] cpu_addr,
   output logic [31:0] cpu_wdata
);
   // idle bus at time zero
   initial begin
      cpu_req = 1'b0;
      cpu_write = 1'b0;
      cpu_size = 2'h0;
      cpu_addr = 32'h0;
      cpu_wdata = 32'h0;
   end
   // request held one cycle; address and data are then inverted so stale values never match
   task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a,
                         input logic [31:0] d);
      @(posedge core_clk);
      cpu_req <= 1'b1;
      cpu_write <= w;
      cpu_size <= sz;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge core_clk);
      cpu_req <= 1'b0;
      cpu_addr <= ~a;
      cpu_wdata <= ~d;
      #1;
   endtask
endmodule

// ===== test/rbd_top_tb.sv
/*
 * rbd_top_tb: board resets and straps, register and cpu accesses, checks.
 * assumes: rbd_pkg and rbd_top compiled first; core_clk at 250 MHz.
 */
`timescale 1ns/1ns
module rbd_top_tb;
   logic core_clk, rst_b, ext_reset_n, test_port_reset_n, debug_port_select;
   logic boot_width_strap, tristate_strap_n, wdog_reset_req, reg_wr, reg_rd;
   logic cpu_req, cpu_write, sys_reset_n_q, ice_reset_n_q, scan_reset_n_q;
   logic ice_enable_q, scan_enable_q, pad_drive_en_q, mclk_src_pll_q, mclk_out_en_q;
   logic remap_q, dec_valid_q, dec_abort_q, per_irqc_q, bank0_select_n_q;
   logic [1:0] cpu_size, scan_op_q, dec_tgt_q;
   logic [2:0] dec_bank_q;
   logic [5:0] dec_bank_cfg_q;
   logic [3:0] scan_ir;
   logic [7:0] reg_addr;
   logic [31:0] cpu_addr, cpu_wdata, reg_wdata, reg_rdata_q, dec_addr_q, sram_rdata_q, rd;
   logic [3:0] codes [4] = '{rbd_pkg::SCAN_EXTEST, rbd_pkg::SCAN_SAMPLE, rbd_pkg::SCAN_BYPASS, 4'h2};
   logic [1:0] ops [4] = '{rbd_pkg::SOP_EXTEST, rbd_pkg::SOP_SAMPLE, rbd_pkg::SOP_BYPASS, 2'h0};
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;

   // design and processor model
   rbd_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .ext_reset_n(ext_reset_n),
      .test_port_reset_n(test_port_reset_n), .debug_port_select(debug_port_select),
      .boot_width_strap(boot_width_strap), .tristate_strap_n(tristate_strap_n),
      .wdog_reset_req(wdog_reset_req), .scan_ir(scan_ir), .cpu_req(cpu_req),
      .cpu_write(cpu_write), .cpu_size(cpu_size), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .sys_reset_n_q(sys_reset_n_q), .ice_reset_n_q(ice_reset_n_q),
      .scan_reset_n_q(scan_reset_n_q), .ice_enable_q(ice_enable_q),
      .scan_enable_q(scan_enable_q), .scan_op_q(scan_op_q), .pad_drive_en_q(pad_drive_en_q),
      .mclk_src_pll_q(mclk_src_pll_q), .mclk_out_en_q(mclk_out_en_q), .remap_q(remap_q),
      .dec_valid_q(dec_valid_q), .dec_tgt_q(dec_tgt_q), .dec_abort_q(dec_abort_q),
      .dec_bank_q(dec_bank_q), .dec_bank_cfg_q(dec_bank_cfg_q), .dec_addr_q(dec_addr_q),
      .per_irqc_q(per_irqc_q), .bank0_select_n_q(bank0_select_n_q), .sram_rdata_q(sram_rdata_q));
   rbd_cpu_model i_cpu (.core_clk(core_clk), .cpu_req(cpu_req), .cpu_write(cpu_write),
      .cpu_size(cpu_size), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));

   // free-running clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask
   // bounded wait for the system reset to lift
   task automatic wait_sys();
      int n;
      n = 0;
      while (sys_reset_n_q !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(sys_reset_n_q, 1);
   endtask
   // board reset: both reset pins low, straps steady past the capture window
   task automatic ext_rst(input logic bw, input logic tn, input logic ds, input logic wd);
      @(posedge core_clk);
      ext_reset_n <= 1'b0;
      test_port_reset_n <= 1'b0;
      boot_width_strap <= bw;
      tristate_strap_n <= tn;
      debug_port_select <= ds;
      wdog_reset_req <= wd;
      @(posedge core_clk);
      wdog_reset_req <= 1'b0;
      repeat (rbd_pkg::STRAP_CYC + 4) @(posedge core_clk);
      ext_reset_n <= 1'b1;
      test_port_reset_n <= 1'b1;
      wait_sys();
      repeat (4) @(posedge core_clk);
      #1;
   endtask

   // main sequence
   initial begin
      {rst_b, ext_reset_n, test_port_reset_n, debug_port_select, reg_wr, reg_rd} = 6'h0;
      {boot_width_strap, tristate_strap_n, wdog_reset_req, scan_ir} = 7'h60;
      {reg_addr, reg_wdata} = 40'h0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      ext_rst(1'b1, 1'b1, 1'b0, 1'b0);
      chk({pad_drive_en_q, ice_enable_q, scan_enable_q, remap_q}, 4'hc);
      reg_read(rbd_pkg::OFS_STRAP, rd);
      chk(rd & 32'h31, 32'h11);
      @(posedge core_clk);
      test_port_reset_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 chk({ice_reset_n_q, scan_reset_n_q}, 2'b01);
      test_port_reset_n <= 1'b1;
      i_cpu.access(1'b0, rbd_pkg::SZ_WORD, 32'h0, 32'h0);
      chk({dec_valid_q, dec_tgt_q, dec_bank_q, dec_abort_q, bank0_select_n_q, dec_bank_cfg_q},
          {1'b1, rbd_pkg::TGT_BANK, 5'h0, 6'h01});
      i_cpu.access(1'b0, rbd_pkg::SZ_WORD, 32'h0140_0000, 32'h0);
      chk(dec_abort_q, 1);
      $display("test boot done");
      // remap, then sram lanes at address zero
      reg_write(rbd_pkg::OFS_REMAP, 32'h1);
      chk(remap_q, 1);
      i_cpu.access(1'b1, rbd_pkg::SZ_WORD, 32'h0, 32'h1122_3344);
      chk(dec_tgt_q, rbd_pkg::TGT_SRAM);
      i_cpu.access(1'b1, rbd_pkg::SZ_BYTE, 32'h1, 32'h0000_aa00);
      i_cpu.access(1'b1, rbd_pkg::SZ_HALF, 32'h2, 32'h5566_0000);
      i_cpu.access(1'b0, rbd_pkg::SZ_WORD, 32'h0, 32'h0);
      chk(sram_rdata_q, 32'h5566_aa44);
      for (int i = 0; i < 8; i++) begin
         i_cpu.access(1'b0, rbd_pkg::SZ_WORD, rbd_pkg::EXT_BASE + (32'(i) << 24), 32'h0);
         chk({dec_tgt_q, dec_bank_q, dec_abort_q}, {rbd_pkg::TGT_BANK, i[2:0], 1'b0});
      end
      i_cpu.access(1'b0, rbd_pkg::SZ_WORD, 32'h0840_0000, 32'h0);
      chk(dec_abort_q, 1);
      i_cpu.access(1'b0, rbd_pkg::SZ_WORD, 32'h0010_0004, 32'h0);
      chk(dec_abort_q, 0);
      i_cpu.access(1'b0, rbd_pkg::SZ_BYTE, 32'hfffe_0003, 32'h0);
      chk({dec_tgt_q, dec_abort_q, per_irqc_q}, {rbd_pkg::TGT_PER, 2'b00});
      chk(dec_addr_q, 32'hfffe_0000);
      i_cpu.access(1'b0, rbd_pkg::SZ_WORD, 32'hffff_f010, 32'h0);
      chk(per_irqc_q, 1);
      $display("test decode done");
      // feature enable, disable and status
      reg_write(rbd_pkg::OFS_FEAT_EN, 32'h3);
      reg_write(rbd_pkg::OFS_FEAT_DIS, 32'h0);
      reg_write(rbd_pkg::OFS_FEAT_DIS, 32'h1);
      repeat (2) @(posedge core_clk);
      #1 chk({mclk_out_en_q, mclk_src_pll_q}, 2'b10);
      reg_read(rbd_pkg::OFS_FEAT_ST, rd);
      chk(rd, 32'h2);
      reg_read(8'h80, rd);
      chk(rd, 32'h0);
      $display("test features done");
      // watchdog reset keeps the boot strap, clears remap and features
      @(posedge core_clk);
      boot_width_strap <= 1'b0;
      wdog_reset_req <= 1'b1;
      @(posedge core_clk);
      wdog_reset_req <= 1'b0;
      #1 chk(sys_reset_n_q, 0);
      wait_sys();
      reg_read(rbd_pkg::OFS_STRAP, rd);
      chk(rd & 32'h31, 32'h31);
      chk({remap_q, mclk_src_pll_q, mclk_out_en_q}, 3'h0);
      // board reset beside a watchdog request, tri-state and scan straps
      ext_rst(1'b0, 1'b0, 1'b1, 1'b1);
      reg_read(rbd_pkg::OFS_STRAP, rd);
      chk(rd & 32'h31, 32'h10);
      chk({pad_drive_en_q, ice_enable_q, scan_enable_q}, 3'b001);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         scan_ir <= codes[i];
         repeat (3) @(posedge core_clk);
         #1 chk(scan_op_q, ops[i]);
      end
      @(posedge core_clk);
      test_port_reset_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 chk({ice_reset_n_q, scan_reset_n_q}, 2'b10);
      $display("test resets done");
      close_out();
   end
endmodule
